// >>> pkg/dcs_pkg.sv
// constants and carrier types for the dual clock four stage shift register
// assumes a single 100 MHz ref_clk domain with inputs already synchronous
package dcs_pkg;
  localparam int STAGES = 4;
  localparam int BUF_DEPTH = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [STAGES-1:0] STAGE_RESET = 4'h0;
  localparam logic [1:0] COUNT_EMPTY = 2'h0;
  localparam logic [1:0] COUNT_FULL = 2'h2;
  localparam int FIELD_STAGE0 = 0;
  localparam int FIELD_STAGE3 = 3;

  typedef struct packed {
    logic [STAGES-1:0] stage;
  } dcs_word_t;

  typedef enum logic [1:0] {
    DCS_SHIFT = 2'b01,
    DCS_LOAD = 2'b10
  } dcs_mode_t;
endpackage : dcs_pkg

// >>> core/dcs_shift_register.sv
// four stage register with a serial right shift clock and a parallel load clock
// assumes all inputs synchronous to ref_clk; clocks are sampled as levels
//
// Operation
// - four stages, serial, parallel inputs and outputs
// - update only on selected clock falling edge
// - mode high: load clock falling loads parallel
// - mode low: shift clock falling shifts right
// - listed mode changes leave stages unchanged
`timescale 1ns/1ps
module dcs_shift_register (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load_mode_select,
  input wire logic shift_clock_n,
  input wire logic load_clock_n,
  input wire logic serial_in,
  input wire logic [dcs_pkg::STAGES-1:0] parallel_in,
  output logic [dcs_pkg::STAGES-1:0] stage_out,
  output logic update_ready,
  output logic word_valid,
  input wire logic word_ready,
  output dcs_pkg::dcs_word_t word_out
);
  import dcs_pkg::*;

  logic [STAGES-1:0] stages;
  logic shift_clock_prev;
  logic load_clock_prev;
  dcs_word_t buf_mem [BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;

  wire dcs_mode_t mode = load_mode_select ? DCS_LOAD : DCS_SHIFT;
  wire shift_fall = shift_clock_prev & ~shift_clock_n;
  wire load_fall = load_clock_prev & ~load_clock_n;
  // only the clock chosen by the mode select can move the stages
  wire shift_edge = (mode == DCS_SHIFT) & shift_fall;
  wire load_edge = (mode == DCS_LOAD) & load_fall;
  // a full buffer stalls the register so that no snapshot is lost
  wire buf_full = (count == COUNT_FULL);
  wire push = (shift_edge | load_edge) & ~buf_full;
  wire pop = word_valid & word_ready;
  wire [STAGES-1:0] shifted = {stages[STAGES-2:0], serial_in};
  logic [STAGES-1:0] next_stages;

  always_comb begin
    next_stages = stages;
    case (mode)
      DCS_SHIFT: if (shift_edge && !buf_full) next_stages = shifted;
      DCS_LOAD: if (load_edge && !buf_full) next_stages = parallel_in;
      default: next_stages = stages;
    endcase
  end

  assign stage_out = stages;
  assign update_ready = ~buf_full;
  assign word_valid = (count != COUNT_EMPTY);
  assign word_out = buf_mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stages <= STAGE_RESET;
      shift_clock_prev <= 1'b0;
      load_clock_prev <= 1'b0;
    end else begin
      stages <= next_stages;
      shift_clock_prev <= shift_clock_n;
      load_clock_prev <= load_clock_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= COUNT_EMPTY;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) buf_mem[wr_ptr] <= '{stage: next_stages};
  end

  sequence load_taken_s;
    load_mode_select && load_fall && update_ready;
  endsequence

  sequence shift_taken_s;
    !load_mode_select && shift_fall && update_ready;
  endsequence

  property stable_after_p(logic cause);
    @(posedge ref_clk) disable iff (reset) cause |=> $stable(stage_out);
  endproperty

  load_update_a: assert property (@(posedge ref_clk) disable iff (reset)
    load_taken_s |=> stage_out == $past(parallel_in))
    else $error("parallel load did not copy inputs");

  shift_update_a: assert property (@(posedge ref_clk) disable iff (reset)
    shift_taken_s |=> stage_out[STAGES-1:1] == $past(stage_out[STAGES-2:0]))
    else $error("right shift did not move stages");

  shift_serial_a: assert property (@(posedge ref_clk) disable iff (reset)
    shift_taken_s |=> stage_out[FIELD_STAGE0] == $past(serial_in))
    else $error("serial input not taken into stage 0");

  other_clock_a: assert property (stable_after_p(
    (load_mode_select && !load_fall) || (!load_mode_select && !shift_fall)))
    else $error("stages moved on a non-selected clock");

  mode_rise_a: assert property (stable_after_p(
    $rose(load_mode_select) && load_clock_n))
    else $error("mode rise with load clock high changed stages");

  mode_fall_a: assert property (stable_after_p(
    $fell(load_mode_select) && shift_clock_n && !load_clock_n))
    else $error("mode fall with shift clock high changed stages");

  stall_hold_a: assert property (stable_after_p(!update_ready))
    else $error("stages moved while buffer full");

  snapshot_a: assert property (@(posedge ref_clk) disable iff (reset)
    (count == COUNT_EMPTY) && push |=> word_valid && word_out.stage == stage_out)
    else $error("buffered word does not match stages");

  buf_bound_a: assert property (@(posedge ref_clk) disable iff (reset)
    count <= COUNT_FULL && (word_valid == (count != COUNT_EMPTY)))
    else $error("buffer count out of range");

  // a fall on the clock that the mode does not select, with no selected fall
  sequence load_ignored_s;
    load_mode_select && shift_fall && !load_fall;
  endsequence

  sequence shift_ignored_s;
    !load_mode_select && load_fall && !shift_fall;
  endsequence

  // no fall on either clock: nothing may move the stages
  sequence idle_clocks_s;
    !shift_fall && !load_fall;
  endsequence

  // the buffer drains its last but one word with nothing arriving
  sequence drain_one_s;
    pop && !push && (count == COUNT_FULL);
  endsequence

  load_ignored_a: assert property (@(posedge ref_clk) disable iff (reset)
    load_ignored_s |=> $stable(stage_out))
    else $error("shift clock moved stages in load mode");

  shift_ignored_a: assert property (@(posedge ref_clk) disable iff (reset)
    shift_ignored_s |=> $stable(stage_out))
    else $error("load clock moved stages in shift mode");

  hold_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
    idle_clocks_s |=> $stable(stage_out))
    else $error("stages moved without a clock fall");

  shift_top_a: assert property (@(posedge ref_clk) disable iff (reset)
    shift_taken_s |=> stage_out[FIELD_STAGE3] == $past(stage_out[FIELD_STAGE3-1]))
    else $error("stage 2 not moved into stage 3");

  // reset is checked on its own, so this one carries no disable
  reset_clear_a: assert property (@(posedge ref_clk)
    reset |=> (stage_out == STAGE_RESET) && !word_valid && update_ready)
    else $error("reset did not clear stages and buffer");

  full_stall_a: assert property (@(posedge ref_clk) disable iff (reset)
    (count == COUNT_FULL) |-> !update_ready && !push)
    else $error("full buffer still accepts a snapshot");

  drain_count_a: assert property (@(posedge ref_clk) disable iff (reset)
    drain_one_s |=> word_valid && (count == 2'h1))
    else $error("buffer count wrong after a pop");

  push_valid_a: assert property (@(posedge ref_clk) disable iff (reset)
    push |=> word_valid)
    else $error("pushed snapshot not shown as valid");
endmodule : dcs_shift_register

// >>> dv/dcs_sink.sv
// receiver model that takes buffered snapshots, stalling at random
// assumes ready is driven on the falling edge of ref_clk
`timescale 1ns/1ps
module dcs_sink (
  input wire logic ref_clk,
  input wire logic stall,
  output logic word_ready
);
  int seed = 32'hc7d4;
  initial word_ready = 1'b0;
  always @(negedge ref_clk) begin
    word_ready <= !stall && (($random(seed) & 3) != 0);
  end
endmodule : dcs_sink

// >>> dv/dcs_shift_register_test.sv
// self-checking bench for the dual clock shift register
// assumes dcs_sink as receiver; inputs change on the falling edge
`timescale 1ns/1ps
module dcs_shift_register_test;
  import dcs_pkg::*;
  logic ref_clk = 0, reset = 1, mode = 0, sclk = 0, lclk = 0, sin = 0, stall = 1;
  logic [3:0] pin = 4'h0, exp_q = 4'h0, q, fifo[$];
  logic upd_rdy, wv, wr;
  dcs_word_t wo;
  int bad_count = 0, cmp_count = 0, seed = 32'hc7d4, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  dcs_shift_register dut (.ref_clk(ref_clk), .reset(reset), .load_mode_select(mode),
    .shift_clock_n(sclk), .load_clock_n(lclk), .serial_in(sin), .parallel_in(pin),
    .stage_out(q), .update_ready(upd_rdy), .word_valid(wv), .word_ready(wr), .word_out(wo));
  dcs_sink sink (.ref_clk(ref_clk), .stall(stall), .word_ready(wr));
  task automatic check(input logic [3:0] got, input logic [3:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic complete_run;
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  function automatic logic [3:0] next_q(input logic m, input logic s, input logic [3:0] p,
    input logic [3:0] cur);
    return m ? p : {cur[2:0], s};
  endfunction : next_q
  // drops both clocks with fresh data and checks the stages
  task automatic fall(input logic m, input logic wrong, input logic [3:0] p);
    @(negedge ref_clk);
    sin = $random(seed);
    pin = p;
    lclk = 0;
    sclk = 0;
    if (!wrong && upd_rdy) begin
      exp_q = next_q(m, sin, pin, exp_q);
      fifo.push_back(exp_q);
    end
    @(negedge ref_clk);
    check(q, exp_q);
  endtask : fall
  // one clock pulse; wrong pulses the clock that the mode does not select
  task automatic op(input logic m, input logic wrong, input logic [3:0] p);
    @(negedge ref_clk) mode = m;
    @(negedge ref_clk);
    if (m ^ wrong) lclk = 1;
    else sclk = 1;
    fall(m, wrong, p);
  endtask : op
  // mode changes while the clock that it selects is already high
  task automatic mode_change(input logic m);
    @(negedge ref_clk) mode = !m;
    @(negedge ref_clk);
    if (m) lclk = 1;
    else sclk = 1;
    @(negedge ref_clk) mode = m;
    @(negedge ref_clk);
    check(q, exp_q);
    fall(m, 1'b0, $random(seed));
  endtask : mode_change
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      complete_run();
    end
    if (!reset && wv && wr) check(wo.stage, fifo.pop_front());
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    reset = 0;
    check(q, 4'h0);
    for (int i = 0; i < 80; i++) begin
      stall = (i < 8);
      op($random(seed), (i % 5) == 4, $random(seed));
    end
    mode_change(1'b1);
    mode_change(1'b0);
    op(1'b1, 1'b0, {1'b1, q[3:1]});
    stall = 0;
    repeat (20) @(negedge ref_clk);
    check({3'h0, wv}, 4'h0);
    complete_run();
  end
endmodule : dcs_shift_register_test
